/* File: rtl/urb_uart_core.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - buffer-empty flag follows transmit buffer state
// - empty request held while flag and enable
// - data write loads buffer, clears empty flag
// - complete flag sets when frame done, buffer empty
// - complete flag clears on service or one-write
// - complete request raised when flag sets, enabled
// - parity bit between last data, first stop
// - transmitter disable waits for pending data
// - disabled transmitter releases output pin
// - receive enable takes over input pin
// - sync mode samples on external clock
// - reception starts on valid start bit
// - second stop bit never examined
// - first stop bit moves frame to buffer
// - unused high data bits read zero
// - receive FIFO carries ninth bit and errors
// - receive-complete flag while unread data present
// - parity is data xor, inverted if odd
// - buffer moves to shifter when idle or after stop
module urb_uart_core
    import urb_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              s_axi_awvalid_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    output logic                   s_axi_awready_o,
    input  wire logic              s_axi_wvalid_i,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    output logic                   s_axi_wready_o,
    output logic                   s_axi_bvalid_o,
    output logic [1:0]             s_axi_bresp_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic              s_axi_arvalid_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    output logic                   s_axi_arready_o,
    output logic                   s_axi_rvalid_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              global_irq_en_i,
    input  wire logic              txc_irq_ack_i,
    input  wire logic              serial_in_pin_i,
    input  wire logic              sync_clock_pin_i,
    output logic                   serial_out_pin_o,
    output logic                   serial_out_pin_oe_o,
    output logic                   serial_in_override_o,
    output logic                   irq_tx_empty_o,
    output logic                   irq_tx_complete_o
);

    // bus slave state
    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic              aw_ok_q, w_ok_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [31:0]       rdata_q, rd_val;
    logic              rd_err, wr_fire, rd_fire, wr_err;
    logic              wr_data, wr_sta, wr_ctl, wr_fmt, wr_baud, pop;

    // control and format
    logic              txcie_q, udrie_q, rxen_q, tx_enable_bit_q, txb8_q;
    urb_fmt_t          fmt_q;
    logic [11:0]       baud_q;
    logic [3:0]        nb;

    // transmitter
    urb_tx_st_t        tx_st_q;
    logic [8:0]        tbuf_q, tx_sh_q;
    logic              udre_q, txc_q, tx_act_q, tx_line_q, tx_par_q, tx_stop2_q;
    logic [3:0]        tx_bit_q;
    logic [11:0]       tx_cnt_q;
    logic              tx_tick, tx_end, tx_load;
    logic              irq_empty_q, irq_txc_q;

    // receiver
    urb_rx_st_t        rx_st_q;
    logic              rs1_q, rs2_q, xs1_q, xs2_q, xs3_q;
    logic              xck_rise, xck_fall, rx_tick;
    logic [11:0]       rx_cnt_q;
    logic [3:0]        rx_bit_q;
    logic [8:0]        rx_sh_q;
    logic              rx_par_q, ovr_pend_q, rx_push;
    urb_rx_ent_t       rx_ent, rx_head;
    logic              rx_full, rx_empty;

    assign nb = urb_nbits(fmt_q.char_size);

    assign s_axi_awready_o      = awready_q;
    assign s_axi_wready_o       = wready_q;
    assign s_axi_bvalid_o       = bvalid_q;
    assign s_axi_bresp_o        = bresp_q;
    assign s_axi_arready_o      = arready_q;
    assign s_axi_rvalid_o       = rvalid_q;
    assign s_axi_rdata_o        = rdata_q;
    assign s_axi_rresp_o        = rresp_q;
    assign serial_out_pin_o     = tx_line_q;
    assign serial_out_pin_oe_o  = tx_act_q;
    assign irq_tx_empty_o       = irq_empty_q;
    assign irq_tx_complete_o    = irq_txc_q;

    // address and data taken in either order
    assign wr_fire = aw_ok_q && w_ok_q && !bvalid_q;
    assign rd_fire = s_axi_arvalid_i && arready_q;
    assign wr_err  = !(aw_addr_q inside {OFS_DATA, OFS_STA, OFS_CTL, OFS_FMT, OFS_BAUD});
    assign wr_data = wr_fire && aw_addr_q == OFS_DATA && w_strb_q[0];
    assign wr_sta  = wr_fire && aw_addr_q == OFS_STA  && w_strb_q[0];
    assign wr_ctl  = wr_fire && aw_addr_q == OFS_CTL  && w_strb_q[0];
    assign wr_fmt  = wr_fire && aw_addr_q == OFS_FMT  && w_strb_q[0];
    assign wr_baud = wr_fire && aw_addr_q == OFS_BAUD;
    assign pop     = rd_fire && s_axi_araddr_i == OFS_DATA && !rx_empty;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_ok_q   <= 1'b0;
            w_ok_q    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid_i && awready_q)
            begin
                awready_q <= 1'b0;
                aw_ok_q   <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_q)
            begin
                wready_q <= 1'b0;
                w_ok_q   <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
            if (wr_fire)
            begin
                aw_ok_q  <= 1'b0;
                w_ok_q   <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_err ? RESP_ERR : RESP_OK;
            end
            if (bvalid_q && s_axi_bready_i)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    always_comb
    begin
        rd_val = '0;
        rd_err = 1'b0;
        unique case (s_axi_araddr_i)
            OFS_DATA: rd_val[7:0] = rx_head.data;
            OFS_STA:
            begin
                rd_val[STA_RXC]  = !rx_empty;
                rd_val[STA_TXC]  = txc_q;
                rd_val[STA_UDRE] = udre_q;
                rd_val[STA_FE]   = !rx_empty && rx_head.frame_err;
                rd_val[STA_DOR]  = !rx_empty && rx_head.overrun;
                rd_val[STA_UPE]  = !rx_empty && rx_head.parity_err;
            end
            OFS_CTL:
            begin
                rd_val[CTL_TXCIE] = txcie_q;
                rd_val[CTL_UDRIE] = udrie_q;
                rd_val[CTL_RXEN]  = rxen_q;
                rd_val[CTL_TX_ENABLE_BIT]  = tx_enable_bit_q;
                rd_val[CTL_RXB8]  = !rx_empty && rx_head.ninth;
                rd_val[CTL_TXB8]  = txb8_q;
            end
            OFS_FMT:  rd_val[6:0]  = fmt_q;
            OFS_BAUD: rd_val[11:0] = baud_q;
            default:  rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OK;
        end
        else if (rd_fire)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_val;
            rresp_q   <= rd_err ? RESP_ERR : RESP_OK;
        end
        else if (rvalid_q && s_axi_rready_i)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // control, format and divider registers
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            txcie_q <= 1'b0;
            udrie_q <= 1'b0;
            rxen_q  <= 1'b0;
            tx_enable_bit_q  <= 1'b0;
            txb8_q  <= 1'b0;
            fmt_q   <= FMT_RST;
            baud_q  <= BAUD_RST;
        end
        else
        begin
            if (wr_ctl)
            begin
                txcie_q <= w_data_q[CTL_TXCIE];
                udrie_q <= w_data_q[CTL_UDRIE];
                rxen_q  <= w_data_q[CTL_RXEN];
                tx_enable_bit_q  <= w_data_q[CTL_TX_ENABLE_BIT];
                txb8_q  <= w_data_q[CTL_TXB8];
            end
            if (wr_fmt)
                fmt_q <= urb_fmt_t'(w_data_q[6:0]);
            if (wr_baud && w_strb_q[0])
                baud_q[7:0] <= w_data_q[7:0];
            if (wr_baud && w_strb_q[1])
                baud_q[11:8] <= w_data_q[11:8];
        end
    end

    // pin inputs pass two flops; edges are taken from the second and third
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rs1_q <= 1'b1;
            rs2_q <= 1'b1;
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
        end
        else
        begin
            rs1_q <= serial_in_pin_i;
            rs2_q <= rs1_q;
            xs1_q <= sync_clock_pin_i;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
        end
    end

    assign xck_rise = xs2_q && !xs3_q;
    assign xck_fall = !xs2_q && xs3_q;

    // tx shifts on falling sync edge
    assign tx_tick = fmt_q.sync_mode ? xck_fall : (tx_cnt_q == 12'h000);
    assign tx_end  = tx_st_q == TX_STOP && tx_tick && (!fmt_q.two_stop || tx_stop2_q);
    assign tx_load = tx_act_q && !udre_q && (tx_st_q == TX_IDLE || tx_end);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tbuf_q <= '0;
            udre_q <= 1'b1;
        end
        else if (wr_data)
        begin
            tbuf_q <= {txb8_q, w_data_q[7:0]};
            udre_q <= 1'b0;
        end
        else if (tx_load)
            udre_q <= 1'b1;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tx_cnt_q <= BAUD_RST;
        else if (tx_st_q == TX_IDLE || tx_cnt_q == 12'h000 || tx_load)
            tx_cnt_q <= baud_q;
        else
            tx_cnt_q <= tx_cnt_q - 12'h001;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_st_q    <= TX_IDLE;
            tx_sh_q    <= '0;
            tx_bit_q   <= 4'h0;
            tx_par_q   <= 1'b0;
            tx_stop2_q <= 1'b0;
            tx_line_q  <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_st_q   <= TX_START;
            tx_sh_q   <= tbuf_q;
            tx_bit_q  <= 4'h0;
            tx_par_q  <= urb_parity(tbuf_q, fmt_q.char_size, fmt_q.parity_mode[0]);
            tx_line_q <= 1'b0;
        end
        else if (tx_tick)
        begin
            unique case (tx_st_q)
                TX_IDLE: tx_line_q <= 1'b1;
                TX_START, TX_DATA:
                begin
                    if (tx_bit_q == nb)
                    begin
                        tx_st_q    <= fmt_q.parity_mode[1] ? TX_PAR : TX_STOP;
                        tx_line_q  <= fmt_q.parity_mode[1] ? tx_par_q : 1'b1;
                        tx_stop2_q <= 1'b0;
                    end
                    else
                    begin
                        tx_st_q   <= TX_DATA;
                        tx_line_q <= tx_sh_q[0];
                        tx_sh_q   <= tx_sh_q >> 1;
                        tx_bit_q  <= tx_bit_q + 4'h1;
                    end
                end
                TX_PAR:
                begin
                    tx_st_q    <= TX_STOP;
                    tx_line_q  <= 1'b1;
                    tx_stop2_q <= 1'b0;
                end
                TX_STOP:
                begin
                    if (tx_end)
                        tx_st_q <= TX_IDLE;
                    tx_stop2_q <= 1'b1;
                end
            endcase
        end
    end

    // complete flag: a setting event beats a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            txc_q <= 1'b0;
        else if (tx_end && udre_q)
            txc_q <= 1'b1;
        else if (txc_irq_ack_i || (wr_sta && w_data_q[STA_TXC]))
            txc_q <= 1'b0;
    end

    // override held until shifter and buffer drain
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tx_act_q <= 1'b0;
        else if (tx_enable_bit_q)
            tx_act_q <= 1'b1;
        else if (tx_st_q == TX_IDLE && udre_q)
            tx_act_q <= 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_empty_q <= 1'b0;
            irq_txc_q   <= 1'b0;
        end
        else
        begin
            irq_empty_q <= udrie_q && udre_q && global_irq_en_i;
            irq_txc_q   <= txcie_q && txc_q && global_irq_en_i;
        end
    end

    // receiver
    assign rx_tick = fmt_q.sync_mode ? xck_rise : (rx_cnt_q == 12'h000);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rx_cnt_q <= BAUD_RST;
        else if (rx_st_q == RX_IDLE)
            rx_cnt_q <= {1'b0, baud_q[11:1]};
        else if (rx_cnt_q == 12'h000)
            rx_cnt_q <= baud_q;
        else
            rx_cnt_q <= rx_cnt_q - 12'h001;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_st_q  <= RX_IDLE;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= '0;
            rx_par_q <= 1'b0;
        end
        else if (!rxen_q)
            rx_st_q <= RX_IDLE;
        else
        begin
            unique case (rx_st_q)
                RX_IDLE:
                begin
                    rx_bit_q <= 4'h0;
                    rx_sh_q  <= '0;
                    if (!rs2_q && (!fmt_q.sync_mode || rx_tick))
                        rx_st_q <= fmt_q.sync_mode ? RX_DATA : RX_START;
                end
                RX_START:
                    if (rx_tick)
                        rx_st_q <= rs2_q ? RX_IDLE : RX_DATA;
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_sh_q[rx_bit_q] <= rs2_q;
                        rx_bit_q          <= rx_bit_q + 4'h1;
                        if (rx_bit_q == nb - 4'h1)
                            rx_st_q <= fmt_q.parity_mode[1] ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (rx_tick)
                    begin
                        rx_par_q <= rs2_q;
                        rx_st_q  <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick)
                        rx_st_q <= RX_IDLE;
            endcase
        end
    end

    assign rx_push = rxen_q && rx_st_q == RX_STOP && rx_tick && !rx_full;

    always_comb
    begin
        rx_ent            = '0;
        rx_ent.data       = rx_sh_q[7:0];
        rx_ent.ninth      = rx_sh_q[8];
        rx_ent.frame_err  = !rs2_q;
        rx_ent.overrun    = ovr_pend_q;
        rx_ent.parity_err = fmt_q.parity_mode[1]
                            && (urb_parity(rx_sh_q, fmt_q.char_size, fmt_q.parity_mode[0]) != rx_par_q);
    end

    // lost frame marks the next stored one
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ovr_pend_q <= 1'b0;
        else if (rxen_q && rx_st_q == RX_STOP && rx_tick && rx_full)
            ovr_pend_q <= 1'b1;
        else if (rx_push)
            ovr_pend_q <= 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            serial_in_override_o <= 1'b0;
        else
            serial_in_override_o <= rxen_q;
    end

    urb_rx_fifo u_rx_fifo (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .push_i     (rx_push),
        .push_ent_i (rx_ent),
        .pop_i      (pop),
        .head_o     (rx_head),
        .full_o     (rx_full),
        .empty_o    (rx_empty)
    );

endmodule : urb_uart_core
`default_nettype wire

/* File: rtl/urb_pkg.sv */
package urb_pkg;

    // register byte offsets on the AXI4-Lite port
    localparam int              ADDR_W    = 5;
    localparam logic [4:0]      OFS_DATA  = 5'h00;
    localparam logic [4:0]      OFS_STA   = 5'h04;
    localparam logic [4:0]      OFS_CTL   = 5'h08;
    localparam logic [4:0]      OFS_FMT   = 5'h0C;
    localparam logic [4:0]      OFS_BAUD  = 5'h10;

    // status register bits
    localparam int              STA_RXC   = 7;
    localparam int              STA_TXC   = 6;
    localparam int              STA_UDRE  = 5;
    localparam int              STA_FE    = 4;
    localparam int              STA_DOR   = 3;
    localparam int              STA_UPE   = 2;

    // control register bits
    localparam int              CTL_TXCIE = 6;
    localparam int              CTL_UDRIE = 5;
    localparam int              CTL_RXEN  = 4;
    localparam int              CTL_TX_ENABLE_BIT  = 3;
    localparam int              CTL_RXB8  = 1;
    localparam int              CTL_TXB8  = 0;

    // format register fields
    localparam int              FMT_CS_LSB = 0;
    localparam int              FMT_STOP2  = 3;
    localparam int              FMT_PM_LSB = 4;
    localparam int              FMT_SYNC   = 6;

    localparam logic [2:0]      CS_NINE   = 3'h7;
    localparam logic [2:0]      CS_RST    = 3'h3;
    localparam logic [11:0]     BAUD_RST  = 12'h01F;
    localparam logic [1:0]      RESP_OK   = 2'h0;
    localparam logic [1:0]      RESP_ERR  = 2'h2;
    localparam int              RX_DEPTH  = 2;

    typedef struct packed {
        logic       sync_mode;
        logic [1:0] parity_mode;
        logic       two_stop;
        logic [2:0] char_size;
    } urb_fmt_t;

    localparam urb_fmt_t        FMT_RST   = '{sync_mode: 1'b0, parity_mode: 2'h0, two_stop: 1'b0, char_size: CS_RST};

    typedef struct packed {
        logic       ninth;
        logic       frame_err;
        logic       overrun;
        logic       parity_err;
        logic [7:0] data;
    } urb_rx_ent_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} urb_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urb_rx_st_t;

    function automatic logic [3:0] urb_nbits(input logic [2:0] cs);
        return (cs == CS_NINE) ? 4'h9 : ({2'h0, cs[1:0]} + 4'h5);
    endfunction : urb_nbits

    function automatic logic urb_parity(input logic [8:0] d, input logic [2:0] cs, input logic odd);
        logic [8:0] m;
        m = 9'h1FF >> (4'h9 - urb_nbits(cs));
        return (^(d & m)) ^ odd;
    endfunction : urb_parity

endpackage : urb_pkg

/* File: rtl/urb_rx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module urb_rx_fifo
    import urb_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        push_i,
    input  wire urb_rx_ent_t push_ent_i,
    input  wire logic        pop_i,
    output urb_rx_ent_t      head_o,
    output logic             full_o,
    output logic             empty_o
);

    urb_rx_ent_t ent_q  [RX_DEPTH];
    urb_rx_ent_t ent_up [RX_DEPTH];
    logic [1:0]  cnt_q;

    assign head_o  = ent_q[0];
    assign full_o  = (cnt_q == 2'(RX_DEPTH));
    assign empty_o = (cnt_q == 2'h0);

    // entries shift toward the head on each read
    genvar i;
    generate
        for (i = 0; i < RX_DEPTH; i++)
        begin : g_ent
            if (i + 1 < RX_DEPTH)
            begin : g_mid
                assign ent_up[i] = ent_q[i + 1];
            end
            else
            begin : g_top
                assign ent_up[i] = '0;
            end

            always_ff @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    ent_q[i] <= '0;
                else if (pop_i && !empty_o)
                begin
                    if (push_i && cnt_q == 2'(i + 1))
                        ent_q[i] <= push_ent_i;
                    else
                        ent_q[i] <= ent_up[i];
                end
                else if (push_i && cnt_q == 2'(i))
                    ent_q[i] <= push_ent_i;
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_q <= 2'h0;
        else if (push_i && !(pop_i && !empty_o) && !full_o)
            cnt_q <= cnt_q + 2'h1;
        else if (!push_i && pop_i && !empty_o)
            cnt_q <= cnt_q - 2'h1;
    end

endmodule : urb_rx_fifo
`default_nettype wire

/* File: bench/urb_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module urb_far_end #(parameter int BT = 8)
(
    input  wire logic        core_clk_i,
    input  wire logic        go_i,
    input  wire logic [11:0] frm_i,
    output logic             line_o
);
    logic [11:0] sh_q = '1;
    int          n_q  = 1;
    // frames open with a low start bit, then shift ones in so the line rests high
    always_ff @(posedge core_clk_i)
    begin
        n_q  <= go_i ? 1 : n_q % BT + 1;
        sh_q <= go_i ? frm_i : (n_q == BT) ? {1'h1, sh_q[11:1]} : sh_q;
    end
    assign line_o = sh_q[0];
endmodule : urb_far_end
`default_nettype wire

/* File: bench/urb_uart_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module urb_uart_sva
(
    input wire logic core_clk_i, rst_b_i, global_irq_en_i, txc_irq_ack_i,
    input wire logic serial_out_pin_o, serial_out_pin_oe_o, irq_tx_empty_o,
    input wire logic irq_tx_complete_o, s_axi_bvalid_o, s_axi_bready_i,
    input wire logic s_axi_rvalid_o, s_axi_rready_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_empty_gated: assert property (irq_tx_empty_o |-> $past(global_irq_en_i))
        else $error("empty request while disabled");
    a_txc_gated: assert property (irq_tx_complete_o |-> $past(global_irq_en_i))
        else $error("complete request while disabled");
    a_irq_off: assert property (!global_irq_en_i |=> !irq_tx_empty_o && !irq_tx_complete_o)
        else $error("request survives global disable");
    a_ack_clears: assert property (txc_irq_ack_i |-> ##2 !irq_tx_complete_o)
        else $error("complete request after service");
    a_idle_high: assert property (!serial_out_pin_oe_o |-> serial_out_pin_o)
        else $error("line low while released");
    a_release_idle: assert property ($fell(serial_out_pin_oe_o) |-> $past(serial_out_pin_o))
        else $error("released in mid frame");
    a_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response repeated");
    a_r_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read response repeated");
    c_empty: cover property (irq_tx_empty_o);
    c_txc: cover property ($rose(irq_tx_complete_o));
    c_release: cover property ($fell(serial_out_pin_oe_o));
endmodule : urb_uart_sva
bind urb_uart_core urb_uart_sva urb_uart_sva_inst (.*);
`default_nettype wire

/* File: bench/uart_tx_rx_buffer_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_tx_rx_buffer_flags_bench
    import urb_pkg::*;
;
    logic        core_clk_i = '0, rst_b_i = '0, global_irq_en_i = '1, txc_irq_ack_i = '0, go = '0;
    logic        s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_arvalid_i = '0, sync_clock_pin_i = '0;
    logic        s_axi_bready_i = '1, s_axi_rready_i = '1, s_axi_awready_o, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, serial_in_pin_i, serial_out_pin_o;
    logic        serial_out_pin_oe_o, serial_in_override_o, irq_tx_empty_o, irq_tx_complete_o;
    logic [4:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [11:0] frm = '1;
    logic [10:0] v;
    logic [7:0]  dv;
    int          fail_count = 0, tests_run = 0, k;
    urb_uart_core urb_uart_core_inst (.*);
    urb_far_end urb_far_end_inst (.core_clk_i, .go_i(go), .frm_i(frm), .line_o(serial_in_pin_i));
    initial
        forever #25 core_clk_i = ~core_clk_i;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic lim(input logic t);
        if (t)
        begin
            fail_count++;
            end_of_test();
        end
    endtask : lim
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_awvalid_i, s_axi_wvalid_i} <= {a, d, 2'h3};
        for (k = 0; k < 200; k++)
        begin
            @(posedge core_clk_i);
            if (s_axi_awready_o)
                s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o)
                s_axi_wvalid_i <= 1'h0;
            if (s_axi_bvalid_o)
                break;
        end
        lim(k >= 200);
        chk("bresp", RESP_OK, s_axi_bresp_o);
    endtask : wr
    task automatic rd(input string n, input logic [4:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OK);
        {s_axi_araddr_i, s_axi_arvalid_i} <= {a, 1'h1};
        for (k = 0; k < 200; k++)
        begin
            @(posedge core_clk_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 1'h0;
            if (s_axi_rvalid_o)
                break;
        end
        lim(k >= 200);
        chk(n, e, s_axi_rdata_o);
        chk(n, r, s_axi_rresp_o);
    endtask : rd
    task automatic cap;
        for (k = 0; k < 400 && serial_out_pin_o; k++)
            tick(1);
        lim(k >= 400);
        tick(4);
        for (int i = 0; i < 11; i++)
        begin
            v[i] = serial_out_pin_o;
            tick(8);
        end
    endtask : cap
    initial
    begin
        tick(10);
        rst_b_i <= 1'h1;
        rd("status_rst", OFS_STA, 32'h20);
        rd("unmapped", 5'h14, 32'h0, RESP_ERR);
        wr(OFS_BAUD, 32'h7);
        wr(OFS_CTL, 32'h68);
        tick(2);
        chk("irq_empty", 1'h1, irq_tx_empty_o);
        global_irq_en_i <= 1'h0;
        tick(3);
        chk("irq_gated", 1'h0, irq_tx_empty_o);
        global_irq_en_i <= 1'h1;
        for (int i = 0; i < 2; i++)
        begin
            dv = i ? 8'h07 : 8'hA5;
            wr(OFS_FMT, i ? 32'h33 : 32'h23);
            wr(OFS_DATA, {24'h0, dv});
            cap();
            chk("frame", {1'h1, ^dv ^ i[0], dv, 1'h0}, v);
            tick(8);
            chk("irq_txc", 1'h1, irq_tx_complete_o);
            rd("status_txc", OFS_STA, 32'h60);
            txc_irq_ack_i <= i[0];
            tick(1);
            txc_irq_ack_i <= 1'h0;
            wr(OFS_STA, {31'h0, ~i[0]} << 6);
            rd("status_clr", OFS_STA, 32'h20);
        end
        wr(OFS_DATA, 32'h55);
        wr(OFS_DATA, 32'h33);
        rd("status_busy", OFS_STA, 32'h0);
        chk("irq_busy", 1'h0, irq_tx_empty_o);
        wr(OFS_CTL, 32'h0);
        for (k = 0; k < 400 && serial_out_pin_oe_o; k++)
            tick(1);
        lim(k >= 400);
        chk("drain", 1'h1, k > 120);
        chk("line_idle", 1'h1, serial_out_pin_o);
        wr(OFS_FMT, 32'h08);
        wr(OFS_CTL, 32'h10);
        tick(2);
        chk("override", 1'h1, serial_in_override_o);
        for (int i = 0; i < 2; i++)
        begin
            frm <= {6'h3F, i ? 5'h0A : 5'h15, 1'h0};
            go <= 1'h1;
            tick(1);
            go <= 1'h0;
            tick(110);
        end
        rd("status_rx", OFS_STA, 32'hE0);
        rd("data_rx0", OFS_DATA, 32'h15);
        rd("data_rx1", OFS_DATA, 32'h0A);
        rd("status_end", OFS_STA, 32'h60);
        end_of_test();
    end
endmodule : uart_tx_rx_buffer_flags_bench
`default_nettype wire
